// ---- inc/flash_cmd_defs.svh ----
`ifndef FLASH_CMD_DEFS_SVH
`define FLASH_CMD_DEFS_SVH

// register offsets on the plain register port
`define REG_STATUS        4'h0
`define REG_CONTROL       4'h1
`define REG_INDEX         4'h2
`define REG_WORD0         4'h3
`define REG_WORD1         4'h4
`define REG_WORD2         4'h5
`define REG_WORD3         4'h6
`define REG_WORD4         4'h7
`define REG_SECURITY      4'h8
`define REG_PROTECT       4'h9

// status register bit positions
`define ST_CCF_BIT        7
`define ST_ACC_BIT        5
`define ST_PV_BIT         4
`define ST_VE1_BIT        1
`define ST_VE0_BIT        0

// command codes
`define CMD_ERASE_BLOCK   8'h09
`define CMD_ERASE_SECTOR  8'h0A
`define CMD_UNSECURE      8'h0B
`define CMD_VERIFY_KEY    8'h0C

// launch index expectations
`define IDX_ERASE         3'h1
`define IDX_UNSECURE      3'h0
`define IDX_KEY           3'h4

// backdoor enable field value that permits key verify
`define BACKDOOR_ON       2'h2

// reset values and the open security value
`define SEC_RESET         2'h0
`define SEC_OPEN          2'h2
`define BACKDOOR_ENABLE_FIELD_RESET       2'h2

// address map: block select in bits 23:16
`define PFLASH_BLOCK      8'h80
`define EEPROM_BLOCK      8'h10
`define SECTOR_BITS       9

// timing: erase pulse in microseconds at the core clock rate
`define ERASE_TIME_US     20
`define CLK_MHZ           40
`define ERASE_CYCLES      (`ERASE_TIME_US * `CLK_MHZ)
`define VERIFY_CYCLES     16'h0040

`endif

// ---- inc/flash_cmd_pkg.sv ----
package flash_cmd_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ERASE,
    ST_VERIFY,
    ST_DONE
  } seq_state_t;

  typedef enum logic [1:0] {
    TGT_BLOCK,
    TGT_SECTOR,
    TGT_ALL
  } erase_target_t;

endpackage

// ---- rtl/flash_addr_check.sv ----
`include "flash_cmd_defs.svh"

// decodes a 24-bit global address into block kind and alignment faults
module flash_addr_check (
  input  wire logic [23:0] global_addr,
  output logic             addr_valid,
  output logic             is_pflash,
  output logic             pflash_misaligned,
  output logic             eeprom_misaligned
);

  always_comb begin
    is_pflash         = (global_addr[23:16] == `PFLASH_BLOCK);
    addr_valid        = is_pflash ||
                        (global_addr[23:16] == `EEPROM_BLOCK);
    pflash_misaligned = (global_addr[2:0] != 3'h0);
    eeprom_misaligned = global_addr[0];
  end

endmodule // flash_addr_check

// ---- rtl/flash_erase_security_commands.sv ----
// Operation
// - software clears the complete flag to launch; it stays low until done
// - block erase is code 09, address high in word 0, low in word 1
// - block erase clears the whole block, verifies, then sets complete
// - access error when index is not 001, 000 or 100 per command
// - access error when the command is not allowed in this mode
// - access error for an invalid 24-bit global address on erases
// - block erase faults unaligned flash phrase or eeprom word address
// - block erase raises protection error when any part is protected
// - verify step sets bit 1 on any error, bit 0 on uncorrectable
// - sector erase is code 0A with address split across words 0 and 1
// - sector erase clears the sector, verifies, then sets complete
// - sector erase faults when address bits 2:0 are not zero
// - sector erase raises protection error when the sector is protected
// - unsecure code 0B erases everything and unsecures only on clean verify
// - failed unsecure verify sets bit 1 and leaves security unchanged
// - unsecure raises protection error when any area is protected
// - key verify code 0C carries four keys compared to the stored key
// - key verify needs enable field equal 10, else access error
// - matching keys release security, then complete is set
// - a mismatch locks out key verify with access error until reset
`include "flash_cmd_defs.svh"

module flash_erase_security_commands #(
  parameter int ERASE_CYCLES  = `ERASE_CYCLES,
  parameter int VERIFY_CYCLES = `VERIFY_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        special_mode,
  input  wire logic        verify_fault,
  input  wire logic        verify_uncorrectable,
  input  wire logic [63:0] stored_key,
  output logic             command_complete_flag,
  output logic             access_error_flag,
  output logic             protection_violation_flag,
  output logic             array_erase_busy,
  output logic             secured
);

  initial begin
    if (ERASE_CYCLES < 1 || VERIFY_CYCLES < 1 ||
        ERASE_CYCLES > 65535 || VERIFY_CYCLES > 65535) begin
      $error("erase and verify counts must fit sixteen bits");
    end
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    flash_cmd_pkg::seq_state_t    state;
    flash_cmd_pkg::erase_target_t target;
    logic [15:0] count;
    logic        ccf;
    logic        acc;
    logic        pv;
    logic        ve1;
    logic        ve0;
    logic        unsec_pending;
    logic        key_locked;
    logic [2:0]  index;
    logic [15:0] word0;
    logic [15:0] word1;
    logic [15:0] word2;
    logic [15:0] word3;
    logic [15:0] word4;
    logic [1:0]  sec;
    logic [1:0]  backdoor_enable_field;
    logic [7:0]  protect;
    logic [15:0] rdata;
    logic        busy;
    logic        closed;
  } state_t;

  state_t cur_reg;
  state_t cur_next;

  logic [23:0] global_addr;
  logic        addr_valid;
  logic        is_pflash;
  logic        pflash_misaligned;
  logic        eeprom_misaligned;
  logic        keys_match;
  logic [15:0] key_word   [4];
  logic [15:0] stored_arr [4];

  assign global_addr = {cur_reg.word0[7:0], cur_reg.word1};

  flash_addr_check u_addr (
    .global_addr       (global_addr),
    .addr_valid        (addr_valid),
    .is_pflash         (is_pflash),
    .pflash_misaligned (pflash_misaligned),
    .eeprom_misaligned (eeprom_misaligned)
  );

  always_comb begin
    key_word[0]   = cur_reg.word1;
    key_word[1]   = cur_reg.word2;
    key_word[2]   = cur_reg.word3;
    key_word[3]   = cur_reg.word4;
    stored_arr[0] = stored_key[15:0];
    stored_arr[1] = stored_key[31:16];
    stored_arr[2] = stored_key[47:32];
    stored_arr[3] = stored_key[63:48];
  end

  flash_key_compare #(.KEY_WORDS(4)) u_key (
    .key_word   (key_word),
    .stored_key (stored_arr),
    .keys_match (keys_match)
  );

  // ----------------------------------------------------------------
  // launch checks
  // ----------------------------------------------------------------
  logic [7:0]  cmd_code;
  logic        launch;
  logic        launch_acc;
  logic        launch_pv;
  logic [15:0] status_word;

  assign cmd_code = cur_reg.word0[15:8];
  // writing one to the complete bit clears it and launches
  assign launch = reg_wr && reg_addr == `REG_STATUS &&
                  reg_wdata[`ST_CCF_BIT] && cur_reg.ccf;

  always_comb begin
    launch_acc = 1'b0;
    launch_pv  = 1'b0;
    unique case (cmd_code)
      `CMD_ERASE_BLOCK: begin
        launch_acc = cur_reg.index != `IDX_ERASE || !addr_valid ||
                     (is_pflash ? pflash_misaligned
                                : eeprom_misaligned);
        launch_pv  = is_pflash ? (cur_reg.protect[7:4] != 4'h0)
                               : cur_reg.protect[0];
      end
      `CMD_ERASE_SECTOR: begin
        launch_acc = cur_reg.index != `IDX_ERASE || !addr_valid ||
                     !is_pflash || pflash_misaligned;
        // one protect bit per quarter of the flash block
        launch_pv  = cur_reg.protect[3'h4 + 3'(global_addr[15:14])];
      end
      `CMD_UNSECURE: begin
        launch_acc = cur_reg.index != `IDX_UNSECURE;
        launch_pv  = cur_reg.protect != 8'h00;
      end
      `CMD_VERIFY_KEY: begin
        launch_acc = cur_reg.index != `IDX_KEY ||
                     cur_reg.backdoor_enable_field != `BACKDOOR_ON ||
                     cur_reg.key_locked || !keys_match;
        // of these commands only unsecure needs special mode, else access error
      end
      default: launch_acc = 1'b1;
    endcase
    if (!special_mode && cmd_code == `CMD_UNSECURE) begin
      launch_acc = 1'b1;
    end
  end

  assign status_word = {8'h00, cur_reg.ccf, 1'b0, cur_reg.acc, cur_reg.pv,
                        2'h0, cur_reg.ve1, cur_reg.ve0};

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    cur_next       = cur_reg;
    cur_next.rdata = 16'h0000;

    if (reg_rd) begin
      unique case (reg_addr)
        `REG_STATUS:   cur_next.rdata = status_word;
        `REG_INDEX:    cur_next.rdata = {13'h0000, cur_reg.index};
        `REG_WORD0:    cur_next.rdata = cur_reg.word0;
        `REG_WORD1:    cur_next.rdata = cur_reg.word1;
        `REG_WORD2:    cur_next.rdata = cur_reg.word2;
        `REG_WORD3:    cur_next.rdata = cur_reg.word3;
        `REG_WORD4:    cur_next.rdata = cur_reg.word4;
        `REG_SECURITY: cur_next.rdata = {12'h000, cur_reg.backdoor_enable_field, cur_reg.sec};
        `REG_PROTECT:  cur_next.rdata = {8'h00, cur_reg.protect};
        default:       cur_next.rdata = 16'h0000;
      endcase
    end

    // command object is only writable while idle
    if (reg_wr && cur_reg.ccf) begin
      unique case (reg_addr)
        `REG_STATUS: begin
          if (reg_wdata[`ST_ACC_BIT]) cur_next.acc = 1'b0;
          if (reg_wdata[`ST_PV_BIT])  cur_next.pv  = 1'b0;
        end
        `REG_INDEX:   cur_next.index   = reg_wdata[2:0];
        `REG_WORD0:   cur_next.word0   = reg_wdata;
        `REG_WORD1:   cur_next.word1   = reg_wdata;
        `REG_WORD2:   cur_next.word2   = reg_wdata;
        `REG_WORD3:   cur_next.word3   = reg_wdata;
        `REG_WORD4:   cur_next.word4   = reg_wdata;
        `REG_PROTECT: cur_next.protect = reg_wdata[7:0];
        default: ;
      endcase
    end

    unique case (cur_reg.state)
      flash_cmd_pkg::ST_IDLE: begin
        if (launch && !cur_reg.acc && !cur_reg.pv) begin
          cur_next.ccf = 1'b0;
          cur_next.ve1 = 1'b0;
          cur_next.ve0 = 1'b0;
          if (launch_acc || launch_pv) begin
            cur_next.acc   = launch_acc;
            cur_next.pv    = launch_pv;
            cur_next.state = flash_cmd_pkg::ST_DONE;
            if (cmd_code == `CMD_VERIFY_KEY && !keys_match &&
                cur_reg.backdoor_enable_field == `BACKDOOR_ON &&
                cur_reg.index == `IDX_KEY) begin
              cur_next.key_locked = 1'b1;
            end
          end else if (cmd_code == `CMD_VERIFY_KEY) begin
            cur_next.sec   = 2'h2;
            cur_next.state = flash_cmd_pkg::ST_DONE;
          end else begin
            cur_next.state  = flash_cmd_pkg::ST_ERASE;
            cur_next.count  = 16'(ERASE_CYCLES - 1);
            cur_next.unsec_pending = (cmd_code == `CMD_UNSECURE);
            cur_next.target = cmd_code == `CMD_ERASE_BLOCK ?
                              flash_cmd_pkg::TGT_BLOCK :
                              cmd_code == `CMD_ERASE_SECTOR ?
                              flash_cmd_pkg::TGT_SECTOR :
                              flash_cmd_pkg::TGT_ALL;
          end
        end else if (launch) begin
          // pending errors must be cleared before a launch takes
          cur_next.state = flash_cmd_pkg::ST_IDLE;
        end
      end
      flash_cmd_pkg::ST_ERASE: begin
        if (cur_reg.count == 16'h0000) begin
          cur_next.state = flash_cmd_pkg::ST_VERIFY;
          cur_next.count = 16'(VERIFY_CYCLES - 1);
        end else begin
          cur_next.count = cur_reg.count - 16'h0001;
        end
      end
      flash_cmd_pkg::ST_VERIFY: begin
        if (verify_fault || verify_uncorrectable) cur_next.ve1 = 1'b1;
        if (verify_uncorrectable) cur_next.ve0 = 1'b1;
        if (cur_reg.count == 16'h0000) begin
          cur_next.state = flash_cmd_pkg::ST_DONE;
          if (cur_reg.unsec_pending && !cur_next.ve1 && !cur_next.ve0) begin
            cur_next.sec = 2'h2;
          end
        end else begin
          cur_next.count = cur_reg.count - 16'h0001;
        end
      end
      flash_cmd_pkg::ST_DONE: begin
        cur_next.ccf           = 1'b1;
        cur_next.unsec_pending = 1'b0;
        cur_next.state         = flash_cmd_pkg::ST_IDLE;
      end
      default: cur_next.state = flash_cmd_pkg::ST_IDLE;
    endcase

    // pins are registered copies so no decode glitch reaches them
    cur_next.busy   = cur_next.state == flash_cmd_pkg::ST_ERASE;
    cur_next.closed = cur_next.sec != `SEC_OPEN;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cur_reg               <= '0;
      cur_reg.state         <= flash_cmd_pkg::ST_IDLE;
      cur_reg.ccf           <= 1'b1;
      cur_reg.sec           <= `SEC_RESET;
      cur_reg.closed        <= 1'b1;
      cur_reg.backdoor_enable_field         <= `BACKDOOR_ENABLE_FIELD_RESET;
    end else begin
      cur_reg <= cur_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata                 = cur_reg.rdata;
  assign command_complete_flag     = cur_reg.ccf;
  assign access_error_flag         = cur_reg.acc;
  assign protection_violation_flag = cur_reg.pv;
  assign array_erase_busy          = cur_reg.busy;
  assign secured                   = cur_reg.closed;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_launch_err;
    launch && cur_reg.ccf && !cur_reg.acc && !cur_reg.pv &&
    (launch_acc || launch_pv);
  endsequence

  chk_busy_low: assert property (@(posedge core_clk) disable iff (!rstn)
    cur_reg.state == flash_cmd_pkg::ST_ERASE |-> !cur_reg.ccf)
    else $error("complete flag high while erasing");

  chk_err_skip: assert property (@(posedge core_clk) disable iff (!rstn)
    s_launch_err |=> !command_complete_flag ##1 command_complete_flag)
    else $error("launch error did not complete at once");

  chk_err_flag: assert property (@(posedge core_clk) disable iff (!rstn)
    s_launch_err |=> (access_error_flag || protection_violation_flag))
    else $error("launch error not flagged");

  chk_erase_len: assert property (@(posedge core_clk) disable iff (!rstn)
    $rose(array_erase_busy) |-> array_erase_busy [*3])
    else $error("erase phase too short");

  chk_key_lock: assert property (@(posedge core_clk) disable iff (!rstn)
    cur_reg.key_locked |=> cur_reg.key_locked)
    else $error("key lockout released before reset");

  chk_unsec_fail: assert property (@(posedge core_clk) disable iff (!rstn)
    cur_reg.state == flash_cmd_pkg::ST_DONE && cur_reg.ve1 &&
    cur_reg.target == flash_cmd_pkg::TGT_ALL && $past(secured)
    |-> secured)
    else $error("security released after failed verify");

  chk_sector_align: assert property (@(posedge core_clk) disable iff (!rstn)
    launch && cmd_code == `CMD_ERASE_SECTOR && global_addr[2:0] != 3'h0
    |-> launch_acc)
    else $error("misaligned sector address accepted");

  chk_backdoor_enable_field_gate: assert property (@(posedge core_clk) disable iff (!rstn)
    launch && cmd_code == `CMD_VERIFY_KEY && cur_reg.backdoor_enable_field != `BACKDOOR_ON
    |-> launch_acc)
    else $error("key verify ran while disabled");

endmodule // flash_erase_security_commands

// ---- rtl/flash_key_compare.sv ----
`include "flash_cmd_defs.svh"

// compares the four supplied key words against the stored backdoor key
module flash_key_compare #(
  parameter int KEY_WORDS = 4
) (
  input  wire logic [15:0] key_word [KEY_WORDS],
  input  wire logic [15:0] stored_key [KEY_WORDS],
  output logic             keys_match
);

  initial begin
    if (KEY_WORDS < 1) begin
      $error("KEY_WORDS must be at least one");
    end
  end

  always_comb begin
    keys_match = 1'b1;
    for (int i = 0; i < KEY_WORDS; i++) begin
      if (key_word[i] != stored_key[i]) begin
        keys_match = 1'b0;
      end
    end
  end

endmodule // flash_key_compare

// ---- test/flash_erase_security_commands_tb.sv ----
`include "flash_cmd_defs.svh"

module flash_erase_security_commands_tb;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        core_clk;
  logic        rstn;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        special_mode;
  logic        verify_fault;
  logic        verify_uncorrectable;
  logic [63:0] stored_key;
  logic        command_complete_flag;
  logic        access_error_flag;
  logic        protection_violation_flag;
  logic        array_erase_busy;
  logic        secured;
  logic [63:0] keys;
  int          fails;
  int          checks_done;

  localparam int ERASE_N  = 4;
  localparam int VERIFY_N = 4;

  flash_erase_security_commands #(
    .ERASE_CYCLES (ERASE_N),
    .VERIFY_CYCLES(VERIFY_N)
  ) dut (
    .core_clk                 (core_clk),
    .rstn                     (rstn),
    .reg_addr                 (reg_addr),
    .reg_wdata                (reg_wdata),
    .reg_wr                   (reg_wr),
    .reg_rd                   (reg_rd),
    .reg_rdata                (reg_rdata),
    .special_mode             (special_mode),
    .verify_fault             (verify_fault),
    .verify_uncorrectable     (verify_uncorrectable),
    .stored_key               (stored_key),
    .command_complete_flag    (command_complete_flag),
    .access_error_flag        (access_error_flag),
    .protection_violation_flag(protection_violation_flag),
    .array_erase_busy         (array_erase_busy),
    .secured                  (secured)
  );

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic do_reset();
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic read_check(input logic [3:0] a, input logic [15:0] exp);
    logic [15:0] d;
    reg_read(a, d);
    check(d, exp);
  endtask

  task automatic set_inputs(input logic mode, input logic f, input logic u);
    @(posedge core_clk);
    special_mode         <= mode;
    verify_fault         <= f;
    verify_uncorrectable <= u;
  endtask

  // loads the words, launches, waits for completion, checks the status
  // and clears the error flags so the next launch is accepted
  task automatic cmd(input logic [7:0] code, input logic [23:0] addr,
                     input logic [2:0] idx, input logic [7:0] exp_st,
                     input logic exp_busy);
    int n;
    reg_write(`REG_WORD0, {code, addr[23:16]});
    if (code == `CMD_VERIFY_KEY) begin
      reg_write(`REG_WORD1, keys[15:0]);
      reg_write(`REG_WORD2, keys[31:16]);
      reg_write(`REG_WORD3, keys[47:32]);
      reg_write(`REG_WORD4, keys[63:48]);
    end else begin
      reg_write(`REG_WORD1, addr[15:0]);
    end
    reg_write(`REG_INDEX, {13'h0000, idx});
    reg_write(`REG_STATUS, 16'h0080);
    #1;
    check({15'h0000, command_complete_flag}, 16'h0000);
    check({15'h0000, array_erase_busy}, {15'h0000, exp_busy});
    n = 0;
    while (command_complete_flag !== 1'b1 && n < 100) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (!exp_busy) begin
      check(16'(n), 16'h0001);
    end else begin
      check(16'(n), 16'(ERASE_N + VERIFY_N + 1));
    end
    check({15'h0000, command_complete_flag}, 16'h0001);
    check(16'(access_error_flag), 16'(exp_st[5]));
    check(16'(protection_violation_flag), 16'(exp_st[4]));
    read_check(`REG_STATUS, {8'h00, exp_st});
    reg_write(`REG_STATUS, 16'h0030);
  endtask

  task automatic test_end(input string name);
    $display("test %s done", name);
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    fails = 0;
    checks_done = 0;
    rstn = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    special_mode = 1'b1;
    verify_fault = 1'b0;
    verify_uncorrectable = 1'b0;
    stored_key = 64'h1357_2468_9BDF_ACE0;
    keys = 64'h1357_2468_9BDF_ACE0;
    do_reset();
    read_check(`REG_STATUS, 16'h0080);
    read_check(`REG_SECURITY, 16'h0008);
    reg_write(`REG_SECURITY, 16'h0002);
    read_check(`REG_SECURITY, 16'h0008);
    read_check(4'hF, 16'h0000);
    check({15'h0000, secured}, 16'h0001);
    test_end("reset");

    cmd(`CMD_ERASE_BLOCK, 24'h800000, 3'h1, 8'h80, 1'b1);
    cmd(`CMD_ERASE_BLOCK, 24'h100000, 3'h1, 8'h80, 1'b1);
    cmd(`CMD_ERASE_SECTOR, 24'h800208, 3'h1, 8'h80, 1'b1);
    test_end("erase");

    cmd(`CMD_ERASE_BLOCK, 24'h800000, 3'h0, 8'hA0, 1'b0);
    cmd(`CMD_ERASE_SECTOR, 24'h800000, 3'h2, 8'hA0, 1'b0);
    cmd(`CMD_UNSECURE, 24'h000000, 3'h1, 8'hA0, 1'b0);
    cmd(`CMD_VERIFY_KEY, 24'h000000, 3'h0, 8'hA0, 1'b0);
    cmd(8'h0D, 24'h800000, 3'h1, 8'hA0, 1'b0);
    test_end("index");

    cmd(`CMD_ERASE_BLOCK, 24'h400000, 3'h1, 8'hA0, 1'b0);
    cmd(`CMD_ERASE_SECTOR, 24'h200000, 3'h1, 8'hA0, 1'b0);
    cmd(`CMD_ERASE_SECTOR, 24'h100000, 3'h1, 8'hA0, 1'b0);
    cmd(`CMD_ERASE_BLOCK, 24'h800004, 3'h1, 8'hA0, 1'b0);
    cmd(`CMD_ERASE_BLOCK, 24'h100001, 3'h1, 8'hA0, 1'b0);
    cmd(`CMD_ERASE_SECTOR, 24'h800203, 3'h1, 8'hA0, 1'b0);
    test_end("address");

    reg_write(`REG_PROTECT, 16'h0010);
    cmd(`CMD_ERASE_BLOCK, 24'h800000, 3'h1, 8'h90, 1'b0);
    cmd(`CMD_ERASE_BLOCK, 24'h100000, 3'h1, 8'h80, 1'b1);
    reg_write(`REG_PROTECT, 16'h0001);
    cmd(`CMD_ERASE_BLOCK, 24'h100000, 3'h1, 8'h90, 1'b0);
    cmd(`CMD_UNSECURE, 24'h000000, 3'h0, 8'h90, 1'b0);
    reg_write(`REG_PROTECT, 16'h00F0);
    cmd(`CMD_ERASE_SECTOR, 24'h800008, 3'h1, 8'h90, 1'b0);
    reg_write(`REG_PROTECT, 16'h0000);
    test_end("protection");

    // a launch while an error flag is still up must be ignored
    reg_write(`REG_INDEX, 16'h0000);
    reg_write(`REG_WORD0, 16'h0980);
    reg_write(`REG_STATUS, 16'h0080);
    repeat (3) @(posedge core_clk);
    reg_write(`REG_STATUS, 16'h0080);
    #1;
    check({15'h0000, command_complete_flag}, 16'h0001);
    read_check(`REG_STATUS, 16'h00A0);
    reg_write(`REG_STATUS, 16'h0030);
    test_end("refused");

    set_inputs(1'b1, 1'b1, 1'b0);
    cmd(`CMD_ERASE_BLOCK, 24'h800000, 3'h1, 8'h82, 1'b1);
    set_inputs(1'b1, 1'b1, 1'b1);
    cmd(`CMD_ERASE_SECTOR, 24'h800000, 3'h1, 8'h83, 1'b1);
    set_inputs(1'b1, 1'b0, 1'b1);
    cmd(`CMD_ERASE_BLOCK, 24'h800000, 3'h1, 8'h83, 1'b1);
    set_inputs(1'b1, 1'b1, 1'b0);
    cmd(`CMD_UNSECURE, 24'h000000, 3'h0, 8'h82, 1'b1);
    check({15'h0000, secured}, 16'h0001);
    set_inputs(1'b0, 1'b0, 1'b0);
    cmd(`CMD_UNSECURE, 24'h000000, 3'h0, 8'hA0, 1'b0);
    set_inputs(1'b1, 1'b0, 1'b0);
    cmd(`CMD_UNSECURE, 24'h000000, 3'h0, 8'h80, 1'b1);
    check({15'h0000, secured}, 16'h0000);
    test_end("unsecure");

    // a wrong key locks out even the right key until the next reset
    do_reset();
    keys = 64'h1357_2468_9BDF_ACE1;
    cmd(`CMD_VERIFY_KEY, 24'h000000, 3'h4, 8'hA0, 1'b0);
    keys = stored_key;
    cmd(`CMD_VERIFY_KEY, 24'h000000, 3'h4, 8'hA0, 1'b0);
    check({15'h0000, secured}, 16'h0001);
    do_reset();
    cmd(`CMD_VERIFY_KEY, 24'h000000, 3'h4, 8'h80, 1'b0);
    check({15'h0000, secured}, 16'h0000);
    read_check(`REG_SECURITY, 16'h000A);
    test_end("backdoor");
    final_report();
  end

  // the tests need well under a thousand cycles; this span leaves wide margin
  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    final_report();
  end
endmodule // flash_erase_security_commands_tb
